// ---- dual_timer_counter.sv ----
// Two 16-bit timer/counters reached through the core's special function register port.
// Assumes a single-cycle register strobe from the core on mclk and asynchronous pins.
`timescale 1ns/100ps
module dual_timer_counter (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic vector_zero_ack,
   input wire logic vector_one_ack,
   input wire logic count_pin_zero,
   input wire logic count_pin_one,
   input wire logic gate_pin_zero,
   input wire logic gate_pin_one,
   output logic overflow_zero,
   output logic overflow_one
);
   logic [7:0] timer_mode_config_reg;
   logic [3:0] run_control_low_reg;
   logic run_zero_reg;
   logic run_one_reg;
   logic overflow_zero_reg;
   logic overflow_one_reg;
   timer_pkg::count_pair_s counter_zero_reg;
   timer_pkg::count_pair_s counter_one_reg;
   logic [3:0] phase_reg;
   logic [3:0] pin_meta_reg;
   logic [3:0] pin_sync_reg;
   logic [1:0] sample_reg;
   logic [1:0] edge_pending_reg;
   logic [7:0] sfr_rdata_reg;

   timer_pkg::timer_mode_e mode_zero;
   timer_pkg::timer_mode_e mode_one;
   logic update_now;
   logic [1:0] tick;
   logic [1:0] enabled;
   timer_pkg::step_result_s step_zero;
   timer_pkg::step_result_s step_one;
   logic [7:0] split_high_next;
   logic split_high_ovf;
   logic set_overflow_zero;
   logic set_overflow_one;
   logic [7:0] read_value;

   // Advance one count pair by one step in the given mode
   function automatic timer_pkg::step_result_s step_count(input timer_pkg::timer_mode_e mode,
                                                        input timer_pkg::count_pair_s cur,
                                                        input logic inc);
      timer_pkg::step_result_s res;
      logic [12:0] wide13;
      logic [16:0] wide16;
      logic [8:0] wide8;
      res.count = cur;
      res.overflow = 1'b0;
      wide13 = {cur.high, cur.low[timer_pkg::prescale_bits-1:0]};
      wide16 = {1'b0, cur.high, cur.low} + 17'h00001;
      wide8 = {1'b0, cur.low} + 9'h001;
      if (inc) begin
         unique case (mode)
            timer_pkg::mode_prescaled: begin
               // Upper three low bits are left alone
               res.count.low[timer_pkg::prescale_bits-1:0] = wide13[timer_pkg::prescale_bits-1:0] + 5'h01;
               if (wide13[timer_pkg::prescale_bits-1:0] == 5'h1f) begin
                  res.count.high = cur.high + 8'h01;
               end
               res.overflow = (wide13 == 13'h1fff);
            end
            timer_pkg::mode_full: begin
               res.count = wide16[15:0];
               res.overflow = wide16[16];
            end
            timer_pkg::mode_reload: begin
               // High byte stays as the reload value
               res.count.low = wide8[8] ? cur.high : wide8[7:0];
               res.overflow = wide8[8];
            end
            timer_pkg::mode_split: begin
               res.count = cur; // Caller handles the split case; timer one holds
            end
         endcase
      end
      return res;
   endfunction

   assign mode_zero = timer_pkg::timer_mode_e'(timer_mode_config_reg[timer_pkg::mode_zero_lsb +: 2]);
   assign mode_one = timer_pkg::timer_mode_e'(timer_mode_config_reg[timer_pkg::mode_one_lsb +: 2]);
   assign update_now = (phase_reg == timer_pkg::update_phase);

   // Gating and count source selection for both timers
   always_comb begin
      enabled[0] = run_zero_reg &
                   (~timer_mode_config_reg[timer_pkg::gate_zero_bit] | pin_sync_reg[2]);
      enabled[1] = run_one_reg &
                   (~timer_mode_config_reg[timer_pkg::gate_one_bit] | pin_sync_reg[3]);
      tick[0] = update_now & enabled[0] &
                (timer_mode_config_reg[timer_pkg::select_zero_bit] ? edge_pending_reg[0] : 1'b1);
      tick[1] = update_now & enabled[1] &
                (timer_mode_config_reg[timer_pkg::select_one_bit] ? edge_pending_reg[1] : 1'b1);
   end

   // Next counts and overflow events
   always_comb begin
      step_zero = step_count(mode_zero, counter_zero_reg, tick[0]);
      step_one = step_count(mode_one, counter_one_reg, tick[1]);
      split_high_next = counter_zero_reg.high;
      split_high_ovf = 1'b0;
      if (mode_zero == timer_pkg::mode_split) begin
         // Low byte is a plain 8-bit counter on timer zero's controls
         step_zero.count.low = counter_zero_reg.low + {7'h00, tick[0]};
         step_zero.overflow = tick[0] & (counter_zero_reg.low == 8'hff);
         // High byte counts machine cycles on timer one's run bit
         if (update_now & run_one_reg) begin
            split_high_next = counter_zero_reg.high + 8'h01;
            split_high_ovf = (counter_zero_reg.high == 8'hff);
         end
         step_zero.count.high = split_high_next;
      end
      set_overflow_zero = step_zero.overflow;
      set_overflow_one = (mode_zero == timer_pkg::mode_split) ? split_high_ovf : step_one.overflow;
   end

   // Machine cycle phase sequencer
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         phase_reg <= 4'h0;
      end else if (phase_reg == timer_pkg::last_phase) begin
         phase_reg <= 4'h0;
      end else begin
         phase_reg <= phase_reg + 4'h1;
      end
   end

   // Two-stage synchroniser for count and gate pins
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pin_meta_reg <= 4'h0;
         pin_sync_reg <= 4'h0;
      end else begin
         pin_meta_reg <= {gate_pin_one, gate_pin_zero, count_pin_one, count_pin_zero};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Falling edge detection once per machine cycle; count lands at the next update phase
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sample_reg <= 2'h0;
         edge_pending_reg <= 2'h0;
      end else begin
         if (phase_reg == timer_pkg::sample_phase) begin
            sample_reg <= pin_sync_reg[1:0];
            edge_pending_reg <= sample_reg & ~pin_sync_reg[1:0];
         end else if (update_now) begin
            edge_pending_reg <= 2'h0;
         end
      end
   end

   // Mode register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         timer_mode_config_reg <= timer_pkg::timer_mode_config_reset;
      end else if (sfr_wr && sfr_addr == timer_pkg::timer_mode_config_addr) begin
         timer_mode_config_reg <= sfr_wdata;
      end
   end

   // Run bits and overflow flags; a set beats a clear in the same cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         run_zero_reg <= timer_pkg::timer_run_control_reset[timer_pkg::run_zero_bit];
         run_one_reg <= timer_pkg::timer_run_control_reset[timer_pkg::run_one_bit];
         overflow_zero_reg <= timer_pkg::timer_run_control_reset[timer_pkg::overflow_zero_bit];
         overflow_one_reg <= timer_pkg::timer_run_control_reset[timer_pkg::overflow_one_bit];
         run_control_low_reg <= timer_pkg::timer_run_control_reset[3:0];
      end else begin
         if (sfr_wr && sfr_addr == timer_pkg::timer_run_control_addr) begin
            run_zero_reg <= sfr_wdata[timer_pkg::run_zero_bit];
            run_one_reg <= sfr_wdata[timer_pkg::run_one_bit];
            overflow_zero_reg <= sfr_wdata[timer_pkg::overflow_zero_bit] | set_overflow_zero;
            overflow_one_reg <= sfr_wdata[timer_pkg::overflow_one_bit] | set_overflow_one;
            run_control_low_reg <= sfr_wdata[3:0];
         end else begin
            overflow_zero_reg <= set_overflow_zero | (overflow_zero_reg & ~vector_zero_ack);
            overflow_one_reg <= set_overflow_one | (overflow_one_reg & ~vector_one_ack);
         end
      end
   end

   // Timer zero count bytes; a software write replaces that byte
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         counter_zero_reg <= {timer_pkg::count_reset, timer_pkg::count_reset};
      end else begin
         counter_zero_reg <= step_zero.count;
         if (sfr_wr && sfr_addr == timer_pkg::counter_zero_low_addr) begin
            counter_zero_reg.low <= sfr_wdata;
         end
         if (sfr_wr && sfr_addr == timer_pkg::counter_zero_high_addr) begin
            counter_zero_reg.high <= sfr_wdata;
         end
      end
   end

   // Timer one count bytes, held in mode three
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         counter_one_reg <= {timer_pkg::count_reset, timer_pkg::count_reset};
      end else begin
         counter_one_reg <= step_one.count;
         if (sfr_wr && sfr_addr == timer_pkg::counter_one_low_addr) begin
            counter_one_reg.low <= sfr_wdata;
         end
         if (sfr_wr && sfr_addr == timer_pkg::counter_one_high_addr) begin
            counter_one_reg.high <= sfr_wdata;
         end
      end
   end

   // Read multiplexer; unmapped addresses read as zero
   always_comb begin
      unique case (sfr_addr)
         timer_pkg::timer_run_control_addr:
            read_value = {overflow_one_reg, run_one_reg, overflow_zero_reg, run_zero_reg, run_control_low_reg};
         timer_pkg::timer_mode_config_addr: read_value = timer_mode_config_reg;
         timer_pkg::counter_zero_low_addr: read_value = counter_zero_reg.low;
         timer_pkg::counter_one_low_addr: read_value = counter_one_reg.low;
         timer_pkg::counter_zero_high_addr: read_value = counter_zero_reg.high;
         timer_pkg::counter_one_high_addr: read_value = counter_one_reg.high;
         default: read_value = 8'h00;
      endcase
   end

   // Registered read data, held until the next read
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata_reg <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata_reg <= read_value;
      end
   end

   assign sfr_rdata = sfr_rdata_reg;
   assign overflow_zero = overflow_zero_reg;
   assign overflow_one = overflow_one_reg;
endmodule

// ---- dual_timer_counter_checker.sv ----
// Checker for the register port and overflow flags of the dual timer/counter.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module dual_timer_counter_checker (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic vector_zero_ack,
   input wire logic vector_one_ack,
   input wire logic count_pin_zero,
   input wire logic count_pin_one,
   input wire logic gate_pin_zero,
   input wire logic gate_pin_one,
   input wire logic overflow_zero,
   input wire logic overflow_one
);
   logic [3:0] phase_reg;
   logic [7:0] mode_reg;
   logic [7:0] ctl_reg;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Machine-cycle phase, in step with the block from reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         phase_reg <= 4'h0;
      end else begin
         phase_reg <= (phase_reg == timer_pkg::last_phase) ? 4'h0 : phase_reg + 4'h1;
      end
   end
   // Shadows of the mode and run control registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode_reg <= timer_pkg::timer_mode_config_reset;
         ctl_reg <= timer_pkg::timer_run_control_reset;
      end else if (sfr_wr && sfr_addr == timer_pkg::timer_mode_config_addr) begin
         mode_reg <= sfr_wdata;
      end else if (sfr_wr && sfr_addr == timer_pkg::timer_run_control_addr) begin
         ctl_reg <= sfr_wdata;
      end
   end
   rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
      else $error("read data changed without a read");
   unmapped_read_a: assert property (sfr_rd && !(sfr_addr inside {[8'h88:8'h8d]}) |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   mode_readback_a: assert property (sfr_rd && !sfr_wr && sfr_addr == timer_pkg::timer_mode_config_addr
      |=> sfr_rdata == mode_reg) else $error("mode register readback wrong");
   run_readback_a: assert property (sfr_rd && !sfr_wr && sfr_addr == timer_pkg::timer_run_control_addr
      |=> {sfr_rdata[6], sfr_rdata[4:0]} == {ctl_reg[6], ctl_reg[4:0]}) else $error("run bits readback wrong");
   zero_set_phase_a: assert property ($rose(overflow_zero) |-> phase_reg == 4'h5 || $past(sfr_wr))
      else $error("overflow zero set off the update phase");
   one_set_phase_a: assert property ($rose(overflow_one) |-> phase_reg == 4'h5 || $past(sfr_wr))
      else $error("overflow one set off the update phase");
   zero_ack_clear_a: assert property (vector_zero_ack && !sfr_wr && phase_reg != 4'h4 |=> !overflow_zero)
      else $error("overflow zero not cleared by vector");
   one_ack_clear_a: assert property (vector_one_ack && !sfr_wr && phase_reg != 4'h4 |=> !overflow_one)
      else $error("overflow one not cleared by vector");
   zero_flag_fall_a: assert property ($fell(overflow_zero) |-> $past(vector_zero_ack) || $past(sfr_wr))
      else $error("overflow zero cleared without cause");
endmodule
bind dual_timer_counter dual_timer_counter_checker u_dual_timer_counter_checker (
   .mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
   .sfr_rdata(sfr_rdata), .vector_zero_ack(vector_zero_ack), .vector_one_ack(vector_one_ack),
   .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one), .gate_pin_zero(gate_pin_zero),
   .gate_pin_one(gate_pin_one), .overflow_zero(overflow_zero), .overflow_one(overflow_one));

// ---- pin_source.sv ----
// External count and gate pin source for the dual timer/counter.
// Assumes the bench clock; pins change just after a rising edge.
`timescale 1ns/100ps
module pin_source (
   input wire logic mclk,
   output logic count_pin_zero,
   output logic count_pin_one,
   output logic gate_pin_zero,
   output logic gate_pin_one
);
   initial begin
      {count_pin_zero, count_pin_one, gate_pin_zero, gate_pin_one} = 4'h0;
   end
   // Gate levels for both timers
   task automatic set_gate(input logic [1:0] g);
      @(posedge mclk);
      {gate_pin_one, gate_pin_zero} <= g;
   endtask
   // Falling edges on one count pin, each level held a full machine cycle
   task automatic pulses(input logic sel, input int n);
      for (int i = 0; i < 2 * n; i++) begin
         @(posedge mclk);
         count_pin_zero <= sel ? count_pin_zero : ~count_pin_zero;
         count_pin_one <= sel ? ~count_pin_one : count_pin_one;
         repeat (11) @(posedge mclk);
      end
   endtask
endmodule

// ---- tb_dual_timer_counter.sv ----
// Self-checking bench: table of timer cases, then counter, flag and reset cases.
// Assumes the pin source model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_dual_timer_counter;
   typedef struct packed {
      logic t; logic [7:0] cfg; logic [7:0] run; logic [1:0] gate;
      logic [15:0] cnt; logic [3:0] n; logic [15:0] exp; logic [1:0] ovf;
   } row_s;
   localparam logic [7:0] ctl_a = timer_pkg::timer_run_control_addr;
   localparam logic [7:0] mode_a = timer_pkg::timer_mode_config_addr;
   // Timer, mode, run, gate pins, start, machine cycles, end count, flags
   localparam row_s rows [15] = '{
      '{1'b0, 8'h01, 8'h10, 2'b00, 16'h00fe, 4'd3, 16'h0101, 2'b00},
      '{1'b0, 8'h01, 8'h10, 2'b00, 16'hffff, 4'd2, 16'h0001, 2'b01},
      '{1'b0, 8'h00, 8'h10, 2'b00, 16'h00fe, 4'd3, 16'h01e1, 2'b00},
      '{1'b0, 8'h00, 8'h10, 2'b00, 16'hff1f, 4'd2, 16'h0001, 2'b01},
      '{1'b0, 8'h02, 8'h10, 2'b00, 16'h80fe, 4'd3, 16'h8081, 2'b01},
      '{1'b0, 8'h03, 8'h50, 2'b00, 16'hfffe, 4'd3, 16'h0201, 2'b11},
      '{1'b0, 8'h09, 8'h10, 2'b00, 16'h1234, 4'd3, 16'h1234, 2'b00},
      '{1'b0, 8'h09, 8'h10, 2'b01, 16'h1234, 4'd3, 16'h1237, 2'b00},
      '{1'b1, 8'h10, 8'h40, 2'b00, 16'hffff, 4'd2, 16'h0001, 2'b10},
      '{1'b1, 8'h30, 8'h40, 2'b00, 16'h1234, 4'd3, 16'h1234, 2'b00},
      '{1'b1, 8'h90, 8'h40, 2'b00, 16'h0005, 4'd2, 16'h0005, 2'b00},
      '{1'b0, 8'h01, 8'h00, 2'b00, 16'h0042, 4'd2, 16'h0042, 2'b00},
      '{1'b1, 8'h90, 8'h40, 2'b10, 16'h0005, 4'd2, 16'h0007, 2'b00},
      '{1'b1, 8'h00, 8'h40, 2'b00, 16'hff1f, 4'd2, 16'h0001, 2'b10},
      '{1'b1, 8'h20, 8'h40, 2'b00, 16'h80fe, 4'd3, 16'h8081, 2'b10}};
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic vector_zero_ack = 1'b0;
   logic vector_one_ack = 1'b0;
   logic [7:0] sfr_rdata, d, hi_a, lo_a;
   logic count_pin_zero, count_pin_one, gate_pin_zero, gate_pin_one, overflow_zero, overflow_one;
   int err_total = 0;
   int checked = 0;
   row_s r;
   dual_timer_counter u_dual_timer_counter (.mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .vector_zero_ack(vector_zero_ack),
      .vector_one_ack(vector_one_ack), .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
      .gate_pin_zero(gate_pin_zero), .gate_pin_one(gate_pin_one), .overflow_zero(overflow_zero),
      .overflow_one(overflow_one));
   pin_source u_pin_source (.mclk(mclk), .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
      .gate_pin_zero(gate_pin_zero), .gate_pin_one(gate_pin_one));
   always #10 mclk = ~mclk;
   // One-cycle register write and read strobes
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, a, v};
      @(posedge mclk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      {sfr_rd, sfr_addr} <= {1'b1, a};
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1;
      v = sfr_rdata;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Cuts a hang short
   initial begin
      repeat (100000) @(posedge mclk);
      err_total++;
      wrap_up();
   end
   initial begin
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         r = rows[i];
         hi_a = r.t ? timer_pkg::counter_one_high_addr : timer_pkg::counter_zero_high_addr;
         lo_a = r.t ? timer_pkg::counter_one_low_addr : timer_pkg::counter_zero_low_addr;
         u_pin_source.set_gate(r.gate);
         wr(hi_a, r.cnt[15:8]);
         wr(lo_a, r.cnt[7:0]);
         wr(mode_a, r.cfg);
         wr(ctl_a, r.run);
         repeat (12 * r.n - 2) @(posedge mclk);
         #1;
         `CHK({overflow_one, overflow_zero}, r.ovf)
         wr(ctl_a, 8'h00);
         rd(hi_a, d);
         `CHK(d, r.exp[15:8])
         rd(lo_a, d);
         `CHK(d, r.exp[7:0])
         $display("row %0d done", i);
      end
      // Falling edges on each count pin
      for (int t = 0; t < 2; t++) begin
         lo_a = t ? timer_pkg::counter_one_low_addr : timer_pkg::counter_zero_low_addr;
         wr(mode_a, t ? 8'h50 : 8'h05);
         wr(lo_a, 8'h00);
         wr(ctl_a, t ? 8'h40 : 8'h10);
         u_pin_source.pulses(t[0], 3);
         repeat (36) @(posedge mclk);
         wr(ctl_a, 8'h00);
         rd(lo_a, d);
         `CHK(d, 8'h03)
      end
      $display("counter test done");
      // Both flags set, then cleared one at a time by vectoring
      wr(mode_a, 8'h11);
      for (int a = 8'h8a; a <= 8'h8d; a++) wr(8'(a), 8'hff);
      wr(ctl_a, 8'h50);
      repeat (14) @(posedge mclk);
      #1;
      `CHK({overflow_one, overflow_zero}, 2'b11)
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk);
         {vector_one_ack, vector_zero_ack} <= 2'(1 << k);
         @(posedge mclk);
         {vector_one_ack, vector_zero_ack} <= 2'b00;
         #1;
         `CHK({overflow_one, overflow_zero}, k ? 2'b00 : 2'b10)
      end
      $display("flag test done");
      // Reset in mid-run, then reset values and an unmapped place
      @(posedge mclk);
      nrst <= 1'b0;
      @(posedge mclk);
      nrst <= 1'b1;
      wr(8'h8e, 8'h5a);
      for (int a = 8'h88; a < 8'h8f; a++) begin
         rd(8'(a), d);
         `CHK(d, 8'h00)
      end
      $display("reset test done");
      wrap_up();
   end
endmodule

// ---- timer_pkg.sv ----
// Constants, register map and carrier types for the dual timer/counter.
// Assumes a core clock that the machine-cycle sequencer divides by twelve.
package timer_pkg;
   localparam logic [7:0] timer_run_control_addr = 8'h88;
   localparam logic [7:0] timer_mode_config_addr = 8'h89;
   localparam logic [7:0] counter_zero_low_addr = 8'h8a;
   localparam logic [7:0] counter_one_low_addr = 8'h8b;
   localparam logic [7:0] counter_zero_high_addr = 8'h8c;
   localparam logic [7:0] counter_one_high_addr = 8'h8d;
   localparam logic [7:0] timer_mode_config_reset = 8'h00;
   localparam logic [7:0] timer_run_control_reset = 8'h00;
   localparam logic [7:0] count_reset = 8'h00;
   // Mode register fields, timer one in the upper nibble
   localparam int gate_one_bit = 7;
   localparam int select_one_bit = 6;
   localparam int mode_one_lsb = 4;
   localparam int gate_zero_bit = 3;
   localparam int select_zero_bit = 2;
   localparam int mode_zero_lsb = 0;
   // Run control register fields
   localparam int overflow_one_bit = 7;
   localparam int run_one_bit = 6;
   localparam int overflow_zero_bit = 5;
   localparam int run_zero_bit = 4;
   // Machine cycle timing
   localparam int clocks_per_cycle = 12;
   localparam logic [3:0] last_phase = 4'(clocks_per_cycle - 1);
   localparam logic [3:0] update_phase = 4'h4;
   localparam logic [3:0] sample_phase = 4'h9;
   localparam int prescale_bits = 5;

   typedef enum logic [1:0] {
      mode_prescaled = 2'b00,
      mode_full = 2'b01,
      mode_reload = 2'b10,
      mode_split = 2'b11
   } timer_mode_e;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } count_pair_s;

   typedef struct packed {
      count_pair_s count;
      logic overflow;
   } step_result_s;
endpackage
